/* eep_map.svh */
// constants for the serial eeprom bus slave
`ifndef EEP_MAP_SVH
`define EEP_MAP_SVH
// device type code: the value is arbitrary
`define EEP_DEV_CODE 4'h0
`define EEP_CODE_MSB 7
`define EEP_CODE_LSB 4
`define EEP_CS_MSB 3
`define EEP_CS_LSB 1
`define EEP_RW_BIT 0
`define EEP_ADDR_W 16
`define EEP_PAGE_BYTES 128
`define EEP_PAGE_W 7
`define EEP_BITS_PER_BYTE 4'h8
`define EEP_FIFO_DEPTH 16
`define EEP_TWC_MS 5
`define EEP_CLK_KHZ 40000
`define EEP_TWC_CYC (`EEP_TWC_MS * `EEP_CLK_KHZ)
`endif

/* eep_pkg.sv */
// types for the serial eeprom bus slave
package eep_pkg;
    typedef enum logic [6:0] {
        EEP_IDLE = 7'b000_0001,
        EEP_CTRL = 7'b000_0010,
        EEP_AHI = 7'b000_0100,
        EEP_ALO = 7'b000_1000,
        EEP_WDAT = 7'b001_0000,
        EEP_RDAT = 7'b010_0000,
        EEP_IGN = 7'b100_0000
    } eep_state_e;
    typedef struct packed {
        logic [6:0] off;
        logic [7:0] data;
    } eep_went_s;
endpackage

/* eep_bus_slave.sv */
// two-wire eeprom slave: command decode, page buffer, timed write, reads
//
// Functional notes
// - first byte after start is control byte; upper four bits hold device type
// - next three bits must equal the three chip select pins
// - control byte bit zero: one reads, zero writes
// - write control byte is followed by high then low address byte
// - on type and select match the device acknowledges and enters read or write
// - write acks control, both address bytes and data; stop starts the write
// - no control byte is acknowledged while the write cycle runs
// - write with inhibit high is acked but nothing is stored
// - after a byte write the pointer holds written address plus one within the page
// - a short write keeps the other page bytes at their old contents
// - up to 127 more bytes are buffered and committed after stop
// - only low seven pointer bits advance on writes, wrapping in the page
// - write inhibit is sampled at stop; later changes do not matter
// - current address read returns byte at last accessed plus one, within the page after a write
// - master nack ends a read; device releases the data line
// - random read loads the pointer from address bytes before restart
// - after a random read the pointer is one past the byte read
// - each master ack advances the pointer and sends the next byte
// - pointer rolls from top address to zero during reads
// - the timed write ends within five milliseconds after stop
// - the receiver holds data low during the ninth clock high phase
`include "eep_map.svh"
`timescale 1ns/100ps
`default_nettype none

module eep_fifo #(
    parameter int unsigned WIDTH = 15,
    parameter int unsigned DEPTH = `EEP_FIFO_DEPTH
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic do_push;
    logic do_pop;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("fifo depth must be a power of two of at least two");
    end

    always_comb begin
        in_ready_o = (count_reg != (AW+1)'(DEPTH));
        out_valid_o = (count_reg != '0);
        out_data_o = store[rd_ptr_reg];
        do_push = in_valid_i && in_ready_o;
        do_pop = out_valid_o && out_ready_i;
    end

    always_ff @(posedge core_clk_i) begin
        if (do_push) begin
            store[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (do_push && !do_pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (do_pop && !do_push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

module eep_bus_slave #(
    parameter int unsigned TWC_CYC = `EEP_TWC_CYC,
    parameter int unsigned FIFO_DEPTH = `EEP_FIFO_DEPTH
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic chip_select_pin_low_i,
    input wire logic chip_select_pin_mid_i,
    input wire logic chip_select_pin_high_i,
    input wire logic write_inhibit_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    output logic write_busy_o
);
    import eep_pkg::*;
    localparam int unsigned CW = $clog2(TWC_CYC + 1);

    if (TWC_CYC < 200) begin : g_chk
        $error("write cycle must outlast the page copy");
    end

    logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
    logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
    logic wp_s1_reg, wp_s2_reg;
    logic [2:0] cs_s1_reg, cs_s2_reg;
    eep_state_e st_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg, tx_reg, addr_hi_reg;
    logic [15:0] ptr_reg;
    logic mack_reg, wr_pend_reg, copy_run_reg;
    logic [CW-1:0] wc_cnt_reg;
    logic [7:0] copy_idx_reg;
    logic [7:0] mem [0:65535];
    logic [7:0] pbuf [0:127];
    logic [127:0] valid_reg;
    logic scl_rise, scl_fall, start_ev, stop_ev, byte_done, ack_done;
    logic ctl_match, ld_next, commit;
    logic f_in_ready, f_out_valid, f_out_ready;
    eep_went_s f_in, f_out;

    // two-flop synchronisers, third stage only for edge finding
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_s3_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_s3_reg <= 1'b1;
            wp_s1_reg <= 1'b0;
            wp_s2_reg <= 1'b0;
            cs_s1_reg <= 3'h0;
            cs_s2_reg <= 3'h0;
        end else begin
            scl_s1_reg <= scl_i;
            scl_s2_reg <= scl_s1_reg;
            scl_s3_reg <= scl_s2_reg;
            sda_s1_reg <= sda_i;
            sda_s2_reg <= sda_s1_reg;
            sda_s3_reg <= sda_s2_reg;
            wp_s1_reg <= write_inhibit_i;
            wp_s2_reg <= wp_s1_reg;
            cs_s1_reg <= {chip_select_pin_high_i, chip_select_pin_mid_i, chip_select_pin_low_i};
            cs_s2_reg <= cs_s1_reg;
        end
    end

    always_comb begin
        scl_rise = scl_s2_reg && !scl_s3_reg;
        scl_fall = !scl_s2_reg && scl_s3_reg;
        start_ev = scl_s2_reg && scl_s3_reg && sda_s3_reg && !sda_s2_reg;
        stop_ev = scl_s2_reg && scl_s3_reg && !sda_s3_reg && sda_s2_reg;
        byte_done = scl_fall && (bit_cnt_reg == `EEP_BITS_PER_BYTE);
        ack_done = scl_fall && (bit_cnt_reg == 4'h0);
        ctl_match = (shift_reg[`EEP_CODE_MSB:`EEP_CODE_LSB] == `EEP_DEV_CODE)
            && (shift_reg[`EEP_CS_MSB:`EEP_CS_LSB] == cs_s2_reg)
            && !write_busy_o;
        // own ack on the ninth clock reads back as acknowledge, so the first byte loads too
        ld_next = ack_done && (st_reg == EEP_RDAT) && mack_reg;
        commit = stop_ev && wr_pend_reg && !wp_s2_reg;
        f_in = '{off: ptr_reg[6:0], data: shift_reg};
        f_out_ready = !copy_run_reg;
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_reg <= EEP_IDLE;
        end else if (start_ev) begin
            st_reg <= EEP_CTRL;
        end else if (stop_ev) begin
            st_reg <= EEP_IDLE;
        end else if (byte_done) begin
            unique case (st_reg)
                EEP_CTRL: begin
                    if (!ctl_match) begin
                        st_reg <= EEP_IGN;
                    end else if (shift_reg[`EEP_RW_BIT]) begin
                        st_reg <= EEP_RDAT;
                    end else begin
                        st_reg <= EEP_AHI;
                    end
                end
                EEP_AHI: st_reg <= EEP_ALO;
                EEP_ALO: st_reg <= EEP_WDAT;
                EEP_WDAT: st_reg <= f_in_ready ? EEP_WDAT : EEP_IGN;
                EEP_RDAT, EEP_IGN, EEP_IDLE: st_reg <= st_reg;
                default: st_reg <= EEP_IDLE;
            endcase
        end else if (ack_done && st_reg == EEP_RDAT && !mack_reg) begin
            st_reg <= EEP_IGN;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || start_ev) begin
            bit_cnt_reg <= 4'h0;
        end else if (scl_rise) begin
            bit_cnt_reg <= (bit_cnt_reg == `EEP_BITS_PER_BYTE) ? 4'h0 : bit_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            shift_reg <= 8'h00;
            mack_reg <= 1'b0;
        end else if (scl_rise) begin
            if (bit_cnt_reg != `EEP_BITS_PER_BYTE) begin
                shift_reg <= {shift_reg[6:0], sda_s2_reg};
            end else begin
                mack_reg <= !sda_s2_reg;
            end
        end
    end

    // open-drain data line: only ever pulls low, changes after a clock fall, released on start and stop
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || start_ev || stop_ev) begin
            sda_oe_n_o <= 1'b1;
            tx_reg <= 8'h00;
        end else if (byte_done) begin
            unique case (st_reg)
                EEP_CTRL: sda_oe_n_o <= !ctl_match;
                EEP_AHI, EEP_ALO: sda_oe_n_o <= 1'b0;
                EEP_WDAT: sda_oe_n_o <= !f_in_ready;
                EEP_RDAT, EEP_IGN, EEP_IDLE: sda_oe_n_o <= 1'b1;
                default: sda_oe_n_o <= 1'b1;
            endcase
        end else if (ld_next) begin
            tx_reg <= mem[ptr_reg];
            sda_oe_n_o <= mem[ptr_reg][7];
        end else if (ack_done) begin
            sda_oe_n_o <= 1'b1;
        end else if (scl_fall && st_reg == EEP_RDAT) begin
            sda_oe_n_o <= tx_reg[6];
            tx_reg <= {tx_reg[6:0], 1'b0};
        end
    end

    always_ff @(posedge core_clk_i) begin
        sda_o <= 1'b0;
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            addr_hi_reg <= 8'h00;
        end else if (byte_done && st_reg == EEP_AHI) begin
            addr_hi_reg <= shift_reg;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ptr_reg <= 16'h0000;
        end else if (byte_done && st_reg == EEP_ALO) begin
            ptr_reg <= {addr_hi_reg, shift_reg};
        end else if (byte_done && st_reg == EEP_WDAT && f_in_ready) begin
            ptr_reg[6:0] <= ptr_reg[6:0] + 7'h01;
        end else if (ld_next) begin
            ptr_reg <= ptr_reg + 16'h0001;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || start_ev || stop_ev) begin
            wr_pend_reg <= 1'b0;
        end else if (byte_done && st_reg == EEP_WDAT && f_in_ready) begin
            wr_pend_reg <= 1'b1;
        end
    end

    eep_fifo #(
        .WIDTH($bits(eep_went_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .in_data_i(f_in),
        .in_valid_i(byte_done && st_reg == EEP_WDAT),
        .in_ready_o(f_in_ready),
        .out_data_o(f_out),
        .out_valid_o(f_out_valid),
        .out_ready_i(f_out_ready)
    );

    // page buffer: later bytes at the same offset overwrite earlier ones
    always_ff @(posedge core_clk_i) begin
        if (f_out_valid && f_out_ready) begin
            pbuf[f_out.off] <= f_out.data;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || (byte_done && st_reg == EEP_ALO)) begin
            valid_reg <= '0;
        end else if (f_out_valid && f_out_ready) begin
            valid_reg[f_out.off] <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            write_busy_o <= 1'b0;
            wc_cnt_reg <= '0;
        end else if (commit) begin
            write_busy_o <= 1'b1;
            wc_cnt_reg <= '0;
        end else if (write_busy_o) begin
            wc_cnt_reg <= wc_cnt_reg + 1'b1;
            if (wc_cnt_reg == CW'(TWC_CYC - 1)) begin
                write_busy_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || commit) begin
            copy_run_reg <= 1'b0;
            copy_idx_reg <= 8'h00;
        end else begin
            copy_run_reg <= write_busy_o && !f_out_valid && !copy_idx_reg[7];
            if (copy_run_reg && !copy_idx_reg[7]) begin
                copy_idx_reg <= copy_idx_reg + 8'h01;
            end
        end
    end

    // untouched page bytes keep their stored value, which stands for the refresh
    always_ff @(posedge core_clk_i) begin
        if (copy_run_reg && !copy_idx_reg[7] && valid_reg[copy_idx_reg[6:0]]) begin
            mem[{ptr_reg[15:7], copy_idx_reg[6:0]}] <= pbuf[copy_idx_reg[6:0]];
        end
    end

    property p_no_ack_busy;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (byte_done && st_reg == EEP_CTRL && write_busy_o) |=> sda_oe_n_o && st_reg == EEP_IGN;
    endproperty
    a_no_ack_busy: assert property (p_no_ack_busy) else $error("ack during write cycle");

    property p_mismatch;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (byte_done && st_reg == EEP_CTRL && shift_reg[7:4] != `EEP_DEV_CODE)
            |=> (sda_oe_n_o && st_reg == EEP_IGN) [*2];
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("mismatch not ignored");

    property p_match_ack;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (byte_done && st_reg == EEP_CTRL && ctl_match)
            |=> !sda_oe_n_o && (st_reg == (shift_reg[0] ? EEP_RDAT : EEP_AHI));
    endproperty
    a_match_ack: assert property (p_match_ack) else $error("match not acked");

    property p_wp_blocks;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (stop_ev && wp_s2_reg && !write_busy_o) |=> !write_busy_o;
    endproperty
    a_wp_blocks: assert property (p_wp_blocks) else $error("protected write ran");

    property p_wc_start;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (stop_ev && wr_pend_reg && !wp_s2_reg) |=> write_busy_o && wc_cnt_reg == '0;
    endproperty
    a_wc_start: assert property (p_wc_start) else $error("write not started");

    property p_wc_bound;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        write_busy_o |-> wc_cnt_reg < CW'(TWC_CYC);
    endproperty
    a_wc_bound: assert property (p_wc_bound) else $error("write cycle too long");

    property p_wr_wrap;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (byte_done && st_reg == EEP_WDAT && f_in_ready)
            |=> ptr_reg[15:7] == $past(ptr_reg[15:7]) && ptr_reg[6:0] == $past(ptr_reg[6:0]) + 7'h01;
    endproperty
    a_wr_wrap: assert property (p_wr_wrap) else $error("write pointer wrong");

    property p_rd_inc;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        ld_next |=> ptr_reg == $past(ptr_reg) + 16'h0001 && tx_reg == mem[$past(ptr_reg)];
    endproperty
    a_rd_inc: assert property (p_rd_inc) else $error("read pointer wrong");

    property p_nack_end;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (ack_done && st_reg == EEP_RDAT && !mack_reg && !start_ev && !stop_ev)
            |=> sda_oe_n_o && st_reg == EEP_IGN;
    endproperty
    a_nack_end: assert property (p_nack_end) else $error("read not ended");

    property p_addr_load;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (byte_done && st_reg == EEP_ALO) |=> ptr_reg == {addr_hi_reg, $past(shift_reg)};
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("address not loaded");
endmodule

`default_nettype wire

/* eep_bus_master_model.sv */
// two-wire bus master model that drives the serial clock
`timescale 1ns/100ps
`default_nettype none
module eep_bus_master_model (
    input wire logic core_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_n_o
);
    initial begin
        scl_o = 1'b1;
        sda_oe_n_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    // data moves one clock after the fall, stays through the high phase
    task automatic bit_io(input logic v, output logic s);
        tick(1);
        sda_oe_n_o <= v;
        tick(3);
        scl_o <= 1'b1;
        tick(4);
        s = sda_i;
        scl_o <= 1'b0;
    endtask
    task automatic start_cond();
        tick(1);
        sda_oe_n_o <= 1'b1;
        tick(3);
        scl_o <= 1'b1;
        tick(4);
        sda_oe_n_o <= 1'b0;
        tick(4);
        scl_o <= 1'b0;
    endtask
    // clock left high and line released between frames
    task automatic stop_cond();
        tick(1);
        sda_oe_n_o <= 1'b0;
        tick(3);
        scl_o <= 1'b1;
        tick(4);
        sda_oe_n_o <= 1'b1;
        tick(4);
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic recv_byte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(~mack, s);
    endtask
endmodule
`default_nettype wire

/* eep_bus_slave_tb_top.sv */
// self-checking bench for the two-wire eeprom slave
`include "eep_map.svh"
`timescale 1ns/100ps
`default_nettype none
module eep_bus_slave_tb_top;
    localparam int unsigned TWC = 300;
    logic core_clk;
    logic sys_rst;
    logic [2:0] cs_pins;
    logic inhibit;
    logic scl;
    logic m_oe_n;
    logic d_oe_n;
    logic busy;
    logic sda_line;
    logic sda_drv;
    logic ack;
    logic [7:0] rd;
    int error_cnt;
    int checks_done;
    // open-drain line with pull-up
    assign sda_line = m_oe_n & (d_oe_n | sda_drv);
    eep_bus_slave #(.TWC_CYC(TWC), .FIFO_DEPTH(16)) i_eep_bus_slave (
        .core_clk_i(core_clk), .sys_rst_i(sys_rst), .scl_i(scl), .sda_i(sda_line),
        .chip_select_pin_low_i(cs_pins[0]), .chip_select_pin_mid_i(cs_pins[1]),
        .chip_select_pin_high_i(cs_pins[2]), .write_inhibit_i(inhibit),
        .sda_o(sda_drv), .sda_oe_n_o(d_oe_n), .write_busy_o(busy));
    eep_bus_master_model i_eep_bus_master_model (
        .core_clk_i(core_clk), .sda_i(sda_line), .scl_o(scl), .sda_oe_n_o(m_oe_n));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    function automatic logic [7:0] ctrl(input logic rw);
        return {`EEP_DEV_CODE, cs_pins, rw};
    endfunction
    task automatic tx(input logic [7:0] b, input logic exp_ack);
        i_eep_bus_master_model.send_byte(b, ack);
        check({15'h0, ack}, {15'h0, exp_ack});
    endtask
    task automatic rx(input logic mack, input logic [7:0] exp);
        i_eep_bus_master_model.recv_byte(mack, rd);
        check({8'h0, rd}, {8'h0, exp});
    endtask
    task automatic addr_cmd(input logic [15:0] a);
        i_eep_bus_master_model.start_cond();
        tx(ctrl(1'b0), 1'b1);
        tx(a[15:8], 1'b1);
        tx(a[7:0], 1'b1);
    endtask
    task automatic rd_start();
        i_eep_bus_master_model.start_cond();
        tx(ctrl(1'b1), 1'b1);
    endtask
    task automatic poll(input logic exp_ack);
        i_eep_bus_master_model.start_cond();
        tx(ctrl(1'b0), exp_ack);
        i_eep_bus_master_model.stop_cond();
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        while (busy === 1'b1 && n < TWC + 400) begin
            @(posedge core_clk);
            n++;
        end
        check({15'h0, busy}, 16'h0000);
    endtask
    task automatic t_page_wrap();
        addr_cmd(16'h017e);
        tx(8'h11, 1'b1);
        tx(8'h22, 1'b1);
        tx(8'h33, 1'b1);
        i_eep_bus_master_model.stop_cond();
        check({15'h0, busy}, 16'h0001);
        poll(1'b0);
        wait_done();
        poll(1'b1);
        $display("test page_wrap done");
    endtask
    task automatic t_byte_write();
        addr_cmd(16'h017d);
        tx(8'h5a, 1'b1);
        i_eep_bus_master_model.stop_cond();
        wait_done();
        rd_start();
        rx(1'b0, 8'h11);
        i_eep_bus_master_model.stop_cond();
        $display("test byte_write done");
    endtask
    task automatic t_random();
        addr_cmd(16'h017d);
        rd_start();
        rx(1'b0, 8'h5a);
        i_eep_bus_master_model.stop_cond();
        rd_start();
        rx(1'b0, 8'h11);
        i_eep_bus_master_model.stop_cond();
        addr_cmd(16'h017e);
        rd_start();
        rx(1'b1, 8'h11);
        rx(1'b0, 8'h22);
        i_eep_bus_master_model.stop_cond();
        $display("test random done");
    endtask
    task automatic t_rollover();
        addr_cmd(16'hffff);
        tx(8'hc3, 1'b1);
        i_eep_bus_master_model.stop_cond();
        wait_done();
        addr_cmd(16'h0000);
        tx(8'h3c, 1'b1);
        i_eep_bus_master_model.stop_cond();
        wait_done();
        addr_cmd(16'hffff);
        rd_start();
        rx(1'b1, 8'hc3);
        rx(1'b0, 8'h3c);
        i_eep_bus_master_model.stop_cond();
        $display("test rollover done");
    endtask
    task automatic t_inhibit();
        @(posedge core_clk);
        inhibit <= 1'b1;
        addr_cmd(16'h0100);
        tx(8'hee, 1'b1);
        i_eep_bus_master_model.stop_cond();
        check({15'h0, busy}, 16'h0000);
        poll(1'b1);
        @(posedge core_clk);
        inhibit <= 1'b0;
        addr_cmd(16'h0101);
        tx(8'h77, 1'b1);
        i_eep_bus_master_model.stop_cond();
        inhibit <= 1'b1;
        check({15'h0, busy}, 16'h0001);
        wait_done();
        inhibit <= 1'b0;
        addr_cmd(16'h0100);
        rd_start();
        rx(1'b1, 8'h33);
        rx(1'b0, 8'h77);
        i_eep_bus_master_model.stop_cond();
        $display("test inhibit done");
    endtask
    task automatic t_mismatch();
        for (int i = 0; i < 3; i++) begin
            i_eep_bus_master_model.start_cond();
            tx({`EEP_DEV_CODE, cs_pins ^ (3'h1 << i), 1'b1}, 1'b0);
            tx(ctrl(1'b0), 1'b0);
            i_eep_bus_master_model.stop_cond();
        end
        i_eep_bus_master_model.start_cond();
        tx({`EEP_DEV_CODE ^ 4'h8, cs_pins, 1'b0}, 1'b0);
        i_eep_bus_master_model.stop_cond();
        @(posedge core_clk);
        cs_pins <= 3'h2;
        repeat (4) @(posedge core_clk);
        poll(1'b1);
        $display("test mismatch done");
    endtask
    initial begin
        sys_rst = 1'b1;
        cs_pins = 3'h5;
        inhibit = 1'b0;
        error_cnt = 0;
        checks_done = 0;
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        t_page_wrap();
        t_byte_write();
        t_random();
        t_rollover();
        t_inhibit();
        t_mismatch();
        summarize();
    end
    // about 6500 cycles expected for all tests
    initial begin
        repeat (40000) @(posedge core_clk);
        error_cnt++;
        $display("watchdog expired");
        summarize();
    end
endmodule
`default_nettype wire
